// *** rtl/pwmp_top.sv ***
// two pulse measurement units with their 8-bit configuration registers
// assumes an 8-bit special register bus with one-cycle write and read strobes
// and raw asynchronous pins; timer gate outputs feed timers 0 and 1
`timescale 1ns/1ns
`include "pwmp_defines.svh"

// Overview of operation
// R1: two independent units, unit 0 paired with timer 0, unit 1 with timer 1.
// R2: software picks start and stop events; timer counts only between them.
// R3: config bit 7 is the interrupt flag, 1 when an event occurred.
// R4: reading bit 6 gives state: 0 waiting for start, 1 counting.
// R5: writing 1 to bit 6 resets unit, clears flag; writing 0 does nothing.
// R6: bit 5 picks end edge: 0 rising, 1 falling.
// R7: bit 4 picks start edge: 0 rising, 1 falling.
// R8: start and end are single edges on the source, never levels.
// R9: unit 0 sources: irq0 pin, serial0 rx, alternate serial0 rx, timer0 count in.
// R10: unit 1 sources: irq1 pin, serial1 rx, alternate serial1 rx, port1 bit6.
// R11: software enables the timer in gating mode right after the unit.
// R12: software loads timer high byte 0, low byte 2 before start.
// R13: on end event the timer stops and holds the cycle count.
// R14: software clears the timer after reading the count.
// R15: flag sets on end event whether or not interrupt is enabled.
// R16: only software write or unit reset clears the flag, never service exit.
// R17: pins are synchronised, edges found by sample compare, gate start to end.
// R18: after start ignore starts; after end ignore all edges until reset.
module pwmp_top (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ext_irq0_pin_i,
  input wire logic serial0_receive_pin_i,
  input wire logic serial0_receive_alt_pin_i,
  input wire logic timer0_count_input_i,
  input wire logic ext_irq1_pin_i,
  input wire logic serial1_receive_pin_i,
  input wire logic serial1_receive_alt_pin_i,
  input wire logic port1_bit6_pin_i,
  output logic timer0_gate_o,
  output logic timer1_gate_o,
  output logic meas0_irq_flag_o,
  output logic meas1_irq_flag_o
);

  // ----------------------------------------
  // configuration storage
  // ----------------------------------------
  pwmp_pkg::pwmp_cfg_t cfg_q [2];
  pwmp_pkg::pwmp_cfg_t cfg_d [2];
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [1:0] sel_wr;
  logic [1:0] state_reset;
  logic [1:0] counting;
  logic [1:0] end_pulse;
  logic [1:0] gate;
  logic [3:0] pins [2];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  // register reset value; only the six stored bits are kept
  localparam logic [7:0] cfg_reset_val = `PWMP_CFG_RESET;

  assign sel_wr[0] = reg_wr_i && (reg_addr_i == `PWMP_CFG0_ADDR);
  assign sel_wr[1] = reg_wr_i && (reg_addr_i == `PWMP_CFG1_ADDR);

  // source order follows the select codes 00..11
  assign pins[0] = {timer0_count_input_i, serial0_receive_alt_pin_i,
                    serial0_receive_pin_i, ext_irq0_pin_i}; // see R9
  assign pins[1] = {port1_bit6_pin_i, serial1_receive_alt_pin_i,
                    serial1_receive_pin_i, ext_irq1_pin_i}; // see R10

  // ----------------------------------------
  // per-unit register, flag and unit instance
  // ----------------------------------------
  genvar u;
  generate
    for (u = 0; u < 2; u++)
    begin : g_unit
      // bit 6 written as 1 is a strobe, never stored
      assign state_reset[u] = sel_wr[u] && reg_wdata_i[`PWMP_STATE_BIT]; // see R5

      always_comb
      begin
        cfg_d[u] = cfg_q[u];
        flag_d[u] = flag_q[u];
        if (sel_wr[u])
        begin
          cfg_d[u] = reg_wdata_i[5:0]; // see R6 see R7
          // software may write the flag either way
          flag_d[u] = reg_wdata_i[`PWMP_IRQ_BIT]; // see R16
        end
        if (state_reset[u])
        begin
          flag_d[u] = 1'b0; // see R5
        end
        // a new end event beats a flag write of 0 in the same cycle; a unit reset suppresses the end event
        if (end_pulse[u])
        begin
          flag_d[u] = 1'b1; // see R15 see R3
        end
      end

      always_ff @(posedge clock_i)
      begin
        if (srst_i)
        begin
          cfg_q[u] <= pwmp_pkg::pwmp_cfg_t'(cfg_reset_val[5:0]);
          flag_q[u] <= 1'b0;
        end
        else
        begin
          cfg_q[u] <= cfg_d[u];
          flag_q[u] <= flag_d[u];
        end
      end

      pwmp_unit u_pwmp_unit (
        .clk_i(clock_i),
        .srst_i(srst_i),
        .src_pins_i(pins[u]),
        .cfg_i(cfg_q[u]),
        .state_reset_i(state_reset[u]),
        .gate_o(gate[u]),
        .counting_o(counting[u]),
        .end_pulse_o(end_pulse[u])
      ); // see R1

      AST_FLAG_SET: assert property (@(posedge clock_i) disable iff (srst_i) // see R15
        end_pulse[u] |=> flag_q[u])
        else $error("flag not set by end event");

      AST_FLAG_CLR: assert property (@(posedge clock_i) disable iff (srst_i) // see R5
        state_reset[u] && !end_pulse[u] |=> !flag_q[u])
        else $error("unit reset did not clear flag");

      AST_FLAG_HOLD: assert property (@(posedge clock_i) disable iff (srst_i) // see R16
        flag_q[u] && !sel_wr[u] |=> flag_q[u])
        else $error("flag dropped without a write");

      AST_CFG_STORE: assert property (@(posedge clock_i) disable iff (srst_i) // see R6 see R7
        sel_wr[u] |=> cfg_q[u] == $past(reg_wdata_i[5:0]))
        else $error("config bits not stored");

      AST_FLAG_WRITE: assert property (@(posedge clock_i) disable iff (srst_i) // see R16
        sel_wr[u] && !state_reset[u] && !end_pulse[u]
          |=> flag_q[u] == $past(reg_wdata_i[`PWMP_IRQ_BIT]))
        else $error("flag did not take the written value");
    end
  endgenerate

  // ----------------------------------------
  // read data, registered one cycle after strobe
  // ----------------------------------------
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `PWMP_CFG0_ADDR: rdata_d = {flag_q[0], counting[0], cfg_q[0]}; // see R3 see R4
        `PWMP_CFG1_ADDR: rdata_d = {flag_q[1], counting[1], cfg_q[1]};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // outputs come straight from registers or the unit state
  assign reg_rdata_o = rdata_q;
  assign timer0_gate_o = gate[0]; // see R13
  assign timer1_gate_o = gate[1];
  assign meas0_irq_flag_o = flag_q[0];
  assign meas1_irq_flag_o = flag_q[1];

  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  // one read strobe, sorted by where it points
  sequence s_read_cfg0;
    reg_rd_i && (reg_addr_i == `PWMP_CFG0_ADDR);
  endsequence

  sequence s_read_cfg1;
    reg_rd_i && (reg_addr_i == `PWMP_CFG1_ADDR);
  endsequence

  sequence s_read_unmapped;
    reg_rd_i && (reg_addr_i != `PWMP_CFG0_ADDR) && (reg_addr_i != `PWMP_CFG1_ADDR);
  endsequence

  AST_READ_STATE: assert property (@(posedge clock_i) disable iff (srst_i) // see R4
    s_read_cfg0 |=> reg_rdata_o[6] == $past(counting[0]))
    else $error("read state bit mismatch");

  AST_READ_STATE1: assert property (@(posedge clock_i) disable iff (srst_i) // see R4
    s_read_cfg1 |=> reg_rdata_o[6] == $past(counting[1]))
    else $error("read state bit mismatch on unit 1");

  AST_READ_FLAG0: assert property (@(posedge clock_i) disable iff (srst_i) // see R3
    s_read_cfg0 |=> reg_rdata_o[7] == $past(flag_q[0]))
    else $error("read flag bit mismatch on unit 0");

  AST_READ_FLAG1: assert property (@(posedge clock_i) disable iff (srst_i) // see R3
    s_read_cfg1 |=> reg_rdata_o[7] == $past(flag_q[1]))
    else $error("read flag bit mismatch on unit 1");

  AST_READ_UNMAPPED: assert property (@(posedge clock_i) disable iff (srst_i) // see R1
    s_read_unmapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // software may poll late, so the byte must not wander between reads
  AST_RDATA_HOLD: assert property (@(posedge clock_i) disable iff (srst_i) // see R4
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

endmodule // pwmp_top

// *** rtl/pwmp_defines.svh ***
// constants for the pulse width measure pair: offsets, fields, reset values
// assumes inclusion by bare name from rtl files of this block
`ifndef PWMP_DEFINES_SVH
`define PWMP_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PWMP_CFG0_ADDR 8'h9e
`define PWMP_CFG1_ADDR 8'h9f

// ----------------------------------------
// field positions
// ----------------------------------------
`define PWMP_IRQ_BIT 7
`define PWMP_STATE_BIT 6
`define PWMP_END_EDGE_BIT 5
`define PWMP_START_EDGE_BIT 4
`define PWMP_END_SRC_HI 3
`define PWMP_END_SRC_LO 2
`define PWMP_START_SRC_HI 1
`define PWMP_START_SRC_LO 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PWMP_CFG_RESET 8'h00

`endif

// *** rtl/pwmp_pkg.sv ***
// types shared by the pulse width measure pair files
// assumes the defines header is compiled alongside
package pwmp_pkg;

  // ----------------------------------------
  // unit state and configuration fields
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWMP_WAIT,
    PWMP_COUNT,
    PWMP_DONE
  } pwmp_state_t;

  typedef struct packed {
    logic end_edge_sel;
    logic start_edge_sel;
    logic [1:0] end_source_sel;
    logic [1:0] start_source_sel;
  } pwmp_cfg_t;

endpackage

// *** rtl/pwmp_unit.sv ***
// one pulse measurement unit: pin sync, edge detect, gate state machine
// assumes asynchronous source pins and a single system clock
`timescale 1ns/1ns
`include "pwmp_defines.svh"

module pwmp_unit (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [3:0] src_pins_i,
  input wire pwmp_pkg::pwmp_cfg_t cfg_i,
  input wire logic state_reset_i,
  output logic gate_o,
  output logic counting_o,
  output logic end_pulse_o
);

  // ----------------------------------------
  // two-stage sync and previous sample
  // ----------------------------------------
  logic [3:0] meta_q;
  logic [3:0] meta_d;
  logic [3:0] sync_q;
  logic [3:0] sync_d;
  logic [3:0] prev_q;
  logic [3:0] prev_d;
  pwmp_pkg::pwmp_state_t state_q;
  pwmp_pkg::pwmp_state_t state_d;
  logic start_hit;
  logic end_hit;
  logic [3:0] rise;
  logic [3:0] fall;

  // sample every pin so switching source costs no sync latency
  always_comb
  begin
    meta_d = src_pins_i;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // no reset here: the stages fill with true pin levels while reset is held,
  // so release never shows a false edge on a pin that idles high; this needs
  // reset held for three or more cycles
  always_ff @(posedge clk_i)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    prev_q <= prev_d;
  end

  // ----------------------------------------
  // edge detect per pin
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_edge
      assign rise[g] = sync_q[g] & ~prev_q[g]; // see R8 see R17
      assign fall[g] = ~sync_q[g] & prev_q[g];
    end
  endgenerate

  // edge polarity: 0 rising, 1 falling
  assign start_hit = cfg_i.start_edge_sel ? fall[cfg_i.start_source_sel]
                                          : rise[cfg_i.start_source_sel]; // see R7 see R9
  assign end_hit = cfg_i.end_edge_sel ? fall[cfg_i.end_source_sel]
                                      : rise[cfg_i.end_source_sel]; // see R6

  // ----------------------------------------
  // gate state machine
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    end_pulse_o = 1'b0;
    unique case (state_q)
      pwmp_pkg::PWMP_WAIT:
      begin
        if (start_hit)
        begin
          state_d = pwmp_pkg::PWMP_COUNT; // see R2
        end
      end
      pwmp_pkg::PWMP_COUNT:
      begin
        // extra start edges are ignored here
        if (end_hit)
        begin
          state_d = pwmp_pkg::PWMP_DONE; // see R13 see R18
          end_pulse_o = 1'b1;
        end
      end
      pwmp_pkg::PWMP_DONE:
      begin
        state_d = pwmp_pkg::PWMP_DONE; // see R18
      end
      default:
      begin
        state_d = pwmp_pkg::PWMP_WAIT;
      end
    endcase
    // software reset wins over any edge in the same cycle
    if (state_reset_i)
    begin
      state_d = pwmp_pkg::PWMP_WAIT; // see R5
      end_pulse_o = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_q <= pwmp_pkg::PWMP_WAIT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign counting_o = (state_q == pwmp_pkg::PWMP_COUNT); // see R4
  assign gate_o = counting_o; // see R17

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_GATE_ON_START: assert property (@(posedge clk_i) disable iff (srst_i) // see R2
    (state_q == pwmp_pkg::PWMP_WAIT) && start_hit && !state_reset_i |=> gate_o)
    else $error("gate did not open on start edge");

  AST_HOLD_AFTER_END: assert property (@(posedge clk_i) disable iff (srst_i) // see R13
    end_pulse_o |=> !gate_o && (state_q == pwmp_pkg::PWMP_DONE))
    else $error("gate still open after end edge");

  AST_DONE_STICKY: assert property (@(posedge clk_i) disable iff (srst_i) // see R18
    (state_q == pwmp_pkg::PWMP_DONE) && !state_reset_i |=> (state_q == pwmp_pkg::PWMP_DONE))
    else $error("done state left without reset");

  AST_RESET_WAITS: assert property (@(posedge clk_i) disable iff (srst_i) // see R5
    state_reset_i |=> (state_q == pwmp_pkg::PWMP_WAIT))
    else $error("unit reset did not return to wait");

  // start edges seen while counting must leave the gate open
  AST_COUNT_HOLDS: assert property (@(posedge clk_i) disable iff (srst_i) // see R18
    (state_q == pwmp_pkg::PWMP_COUNT) && !end_hit && !state_reset_i |=> gate_o)
    else $error("gate closed without an end edge");

  // pin 0 low, then high and held for two samples
  sequence s_pin0_rise;
    !src_pins_i[0] ##1 src_pins_i[0];
  endsequence

  AST_SYNC_LATENCY: assert property (@(posedge clk_i) disable iff (srst_i) // see R17
    s_pin0_rise ##1 src_pins_i[0] |=> rise[0])
    else $error("pin edge not seen after two sync stages");

endmodule // pwmp_unit

// *** test/pwmp_pulse_model.sv ***
// pulse source model: eight pin levels that the bench loads or toggles
// assumes the bench drives the load and toggle inputs just after a clock edge
`timescale 1ns/1ns

module pwmp_pulse_model (
  input wire logic clock_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic [7:0] toggle_i,
  output logic [7:0] pins_o
);
  // one clean transition per toggle; levels hold between pulses, no glitches
  always_ff @(posedge clock_i)
  begin
    if (load_i)
    begin
      pins_o <= load_val_i;
    end
    else
    begin
      pins_o <= pins_o ^ toggle_i;
    end
  end
endmodule // pwmp_pulse_model

// *** test/test_pwmp_top.sv ***
// bench for the pulse width measure pair: register access and gate timing
// assumes the pulse source model drives all eight source pins
`timescale 1ns/1ns

module test_pwmp_top;
  logic clk;
  logic srst;
  logic [7:0] addr, wdata, rdata, pins, ld_val, tgl;
  logic wr_s, rd_s, ld;
  logic [1:0] gate, flag;
  int n_errors, cmp_count;
  int gcnt [2];

  pwmp_pulse_model u_pwmp_pulse_model (.clock_i(clk), .load_i(ld), .load_val_i(ld_val),
    .toggle_i(tgl), .pins_o(pins));

  pwmp_top u_pwmp_top (.clock_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .ext_irq0_pin_i(pins[0]),
    .serial0_receive_pin_i(pins[1]), .serial0_receive_alt_pin_i(pins[2]),
    .timer0_count_input_i(pins[3]), .ext_irq1_pin_i(pins[4]), .serial1_receive_pin_i(pins[5]),
    .serial1_receive_alt_pin_i(pins[6]), .port1_bit6_pin_i(pins[7]),
    .timer0_gate_o(gate[0]), .timer1_gate_o(gate[1]),
    .meas0_irq_flag_o(flag[0]), .meas1_irq_flag_o(flag[1]));

  // ----------------------------------------
  // clock, gate counters, helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts only while a gate is high, so a bench clear never races it
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (gate[i] === 1'b1)
        gcnt[i] <= gcnt[i] + 1;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // read data is registered: settled just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic flip(input logic [7:0] m);
    @(posedge clk);
    tgl <= m;
    @(posedge clk);
    tgl <= 8'h00;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    rd(8'h9e, v);
    chk("cfg0 reset", 8'h00, v);
    rd(8'h9f, v);
    chk("cfg1 reset", 8'h00, v);
    wr(8'h9d, 8'hff);
    rd(8'h9d, v);
    chk("unmapped", 8'h00, v);
    rd(8'h9e, v);
    chk("cfg0 kept", 8'h00, v);
  endtask

  // start pin and end pin sit at their pre-edge levels; same pin needs ep = ~sp
  task automatic t_measure(input int u, input int s, input int e, input logic sp,
    input logic ep, input int n);
    logic [7:0] v, cfg, sm, em;
    sm = 8'h01 << (4 * u + s);
    em = 8'h01 << (4 * u + e);
    cfg = {2'b01, ep, sp, e[1:0], s[1:0]};
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= ((ep ? em : 8'h00) & ~sm) | (sp ? sm : 8'h00);
    @(posedge clk);
    ld <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'h9e + u[7:0], cfg);
    repeat (4) @(posedge clk);
    #1;
    // timer stand-in: armed after the unit and cleared only before each start;
    // its gate has no start latency, so preset is zero
    gcnt[0] = 0;
    gcnt[1] = 0;
    chk("gate on level", 8'h00, {7'h00, gate[u]});
    flip(sm);
    repeat (4) @(posedge clk);
    rd(8'h9e + u[7:0], v);
    chk("cfg counting", cfg, v);
    repeat (n - 8) @(posedge clk);
    flip(em);
    repeat (4) @(posedge clk);
    flip(sm);
    flip(sm);
    flip(em);
    flip(em);
    repeat (4) @(posedge clk);
    #1;
    chk("gate cycles", n[7:0], gcnt[u][7:0]);
    chk("other gate", 8'h00, gcnt[1 - u][7:0]);
    chk("flag pin", 8'h01, {7'h00, flag[u]});
    rd(8'h9e + u[7:0], v);
    chk("cfg done", cfg ^ 8'hc0, v);
  endtask

  task automatic t_clear(input int u);
    logic [7:0] a, v;
    a = 8'h9e + u[7:0];
    t_measure(u, 0, 0, 1'b0, 1'b1, 12);
    wr(a, 8'h81);
    rd(a, v);
    chk("bit6 zero", 8'h81, v);
    wr(a, 8'h01);
    rd(a, v);
    chk("sw clear", 8'h01, v);
    wr(a, 8'h80);
    wr(a, 8'h40);
    flip(8'h01 << (4 * u));
    repeat (4) @(posedge clk);
    rd(a, v);
    chk("restart", 8'h40, v);
    wr(a, 8'h80);
    rd(a, v);
    chk("bit6 zero run", 8'hc0, v);
    wr(a, 8'h40);
    rd(a, v);
    chk("mid reset", 8'h00, v);
    chk("mid gate", 8'h00, {6'h00, flag[u], gate[u]});
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 3000 cycles
  initial
  begin
    #1_000_000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    ld = 1'b1;
    ld_val = 8'h00;
    tgl = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    gcnt[0] = 0;
    gcnt[1] = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    ld <= 1'b0;
    t_regs();
    for (int u = 0; u < 2; u++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        t_measure(u, s, s, s[0], ~s[0], 12 + s);
        t_measure(u, s, (s + 1) % 4, s[0], s[1], 9 + s);
      end
      t_clear(u);
    end
    report_and_stop();
  end
endmodule // test_pwmp_top
